// ==== rtl/iscr_cfg.svh ====
// constants of the upper image sensor control bank (73h..7Dh)
// assumes inclusion by bare name from rtl files; definitions only
`ifndef ISCR_CFG_SVH
`define ISCR_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ISCR_OFS_RISE_SHIFT 8'h72
`define ISCR_OFS_FALL_SHIFT 8'h73
`define ISCR_OFS_GAIN_RATE 8'h74
`define ISCR_OFS_FLIP_EXP 8'h75
`define ISCR_OFS_POWER_TRI 8'h76
`define ISCR_OFS_FAST_THR 8'h77
`define ISCR_OFS_LUMA_OFS 8'h78
`define ISCR_OFS_BLUE_OFS 8'h79
`define ISCR_OFS_RED_OFS 8'h7a
`define ISCR_OFS_RESERVED_SLOT_A_A 8'h7b
`define ISCR_OFS_AVG 8'h7c
`define ISCR_OFS_BLACK_VS 8'h7d
`define ISCR_OFS_RESERVED_SLOT_A_B 8'h7e
`define ISCR_OFS_RESERVED_SLOT_A_C 8'h7f
`define ISCR_NUM_REGS 11

// ************************************************************
// reset values
// ************************************************************
`define ISCR_RST_FALL_SHIFT 8'h50
`define ISCR_RST_GAIN_RATE 8'h20
`define ISCR_RST_FLIP_EXP 8'h02
`define ISCR_RST_POWER_TRI 8'h05
`define ISCR_RST_FAST_THR 8'hf3
`define ISCR_RST_OFS 8'h80
`define ISCR_RST_RESERVED_SLOT_A 8'h00
`define ISCR_RST_AVG 8'h00
`define ISCR_RST_BLACK_VS 8'h77
`define ISCR_RD_UNMAPPED 8'h00

// ************************************************************
// writable bit masks (reserved bits keep their reset value)
// ************************************************************
`define ISCR_WM_ALL 8'hff
`define ISCR_WM_GAIN_RATE 8'hef
`define ISCR_WM_FLIP_EXP 8'h8c
`define ISCR_WM_POWER_TRI 8'ha7
`define ISCR_WM_FAST_THR 8'hc0
`define ISCR_WM_NONE 8'h00
`define ISCR_WM_BLACK_VS 8'hc4

// ************************************************************
// field positions
// ************************************************************
`define ISCR_B_UV_AWB 7
`define ISCR_B_GAIN_HI 6
`define ISCR_B_GAIN_LO 5
`define ISCR_B_RATE_SET 3
`define ISCR_B_VFLIP 7
`define ISCR_B_DROP_CHG 3
`define ISCR_B_SMOOTH 2
`define ISCR_B_TRI_PD 7
`define ISCR_B_SW_PD 5
`define ISCR_B_TRI_TIMING 2
`define ISCR_B_FAST_HI 7
`define ISCR_B_FAST_LO 6
`define ISCR_B_BL_CAL 7
`define ISCR_B_BL_EN 6
`define ISCR_B_VS_DROP 2

// ************************************************************
// decoded values
// ************************************************************
`define ISCR_HSYNC_MAX 10'h035a
`define ISCR_GAIN_DB_6 5'h06
`define ISCR_GAIN_DB_12 5'h0c
`define ISCR_GAIN_DB_18 5'h12
`define ISCR_RATE_SEL_A 3'h1
`define ISCR_RATE_SEL_B 3'h2
`define ISCR_RATE_SEL_C 3'h4
`define ISCR_FIELDS_32 9'h020
`define ISCR_FIELDS_64 9'h040
`define ISCR_FIELDS_128 9'h080
`define ISCR_FIELDS_256 9'h100
`define ISCR_OFS_ZERO 9'h080

`endif

// ==== rtl/iscr_pkg.sv ====
// types shared by both ends of the control bank link
// assumes iscr_cfg.svh for the numbers
package iscr_pkg;

  // ************************************************************
  // host sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    ISCR_HS_IDLE = 2'b00,
    ISCR_HS_WAIT = 2'b01
  } iscr_hstate_type;

  typedef logic [7:0] iscr_byte_type;

endpackage : iscr_pkg

// ==== rtl/iscr_link_if.sv ====
// register access link between host controller and sensor bank
// assumes one shared clock; request is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface iscr_link_if;
  logic req;
  logic we;
  iscr_pkg::iscr_byte_type addr;
  iscr_pkg::iscr_byte_type wdata;
  logic ack;
  iscr_pkg::iscr_byte_type rdata;

  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : iscr_link_if
`default_nettype wire

// ==== rtl/iscr_offset.sv ====
// converts an offset register (80h = zero) into a signed offset
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "iscr_cfg.svh"
module iscr_offset #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // code in, signed offset out
  input wire logic [W-1:0] code,
  output logic signed [W:0] offset
);
  wire logic [W:0] diff_nxt = {1'b0, code} - `ISCR_OFS_ZERO;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      offset <= '0;
    end else begin
      offset <= $signed(diff_nxt);
    end
  end
endmodule : iscr_offset
`default_nettype wire

// ==== rtl/iscr_device.sv ====
// sensor-side upper control bank 73h..7Dh with its decoded controls
// assumes host keeps to the link: one-cycle req, answer a cycle later
`timescale 1ns/10ps
`default_nettype none
`include "iscr_cfg.svh"
module iscr_device #(
  parameter int OFS_W = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register link
  iscr_link_if.device LINK,
  // inputs from neighbouring control registers and the timing path
  input wire logic [1:0] FALL_SHIFT_UPPER,
  input wire logic AVG_ENABLE,
  input wire logic FRAME_DROPPED,
  // sync timing controls
  output logic [9:0] HSYNC_FALL_POS,
  output logic VSYNC_ENABLE,
  output logic VFLIP,
  // exposure and gain controls
  output logic UV_AWB_EN,
  output logic [4:0] MAX_GAIN_DB,
  output logic [8:0] EXP_UPDATE_FIELDS,
  output logic EXP_CODE_BAD,
  output logic DROP_ON_EXP_JUMP,
  output logic SMOOTH_LOW_EXP,
  output logic [1:0] EXP_LOW_BITS,
  output logic FAST_HI_THR,
  output logic FAST_LO_THR,
  output logic [7:0] AVG_LEVEL,
  output logic AVG_LEVEL_VALID,
  // colour offsets
  output logic signed [OFS_W:0] LUMA_OFFSET,
  output logic signed [OFS_W:0] BLUE_OFFSET,
  output logic signed [OFS_W:0] RED_OFFSET,
  // black line
  output logic BLACK_LINE_EN,
  output logic BLACK_LINE_CAL,
  // power and pad control
  output logic POWER_DOWN,
  output logic DATA_OE_N,
  output logic TIMING_OE_N
);

  // ************************************************************
  // register array, indexed from 73h
  // ************************************************************
  localparam logic [7:0] RST_VAL [0:`ISCR_NUM_REGS-1] = '{
    `ISCR_RST_FALL_SHIFT, `ISCR_RST_GAIN_RATE, `ISCR_RST_FLIP_EXP,
    `ISCR_RST_POWER_TRI, `ISCR_RST_FAST_THR, `ISCR_RST_OFS, `ISCR_RST_OFS,
    `ISCR_RST_OFS, `ISCR_RST_RESERVED_SLOT_A, `ISCR_RST_AVG, `ISCR_RST_BLACK_VS};
  localparam logic [7:0] WR_MASK [0:`ISCR_NUM_REGS-1] = '{
    `ISCR_WM_ALL, `ISCR_WM_GAIN_RATE, `ISCR_WM_FLIP_EXP,
    `ISCR_WM_POWER_TRI, `ISCR_WM_FAST_THR, `ISCR_WM_ALL, `ISCR_WM_ALL,
    `ISCR_WM_ALL, `ISCR_WM_NONE, `ISCR_WM_ALL, `ISCR_WM_BLACK_VS};

  logic [7:0] reg_r [0:`ISCR_NUM_REGS-1];
  logic ack_r;
  logic [7:0] rdata_r;

  wire logic [7:0] rel_addr = LINK.addr - `ISCR_OFS_FALL_SHIFT;
  wire logic hit = (LINK.addr >= `ISCR_OFS_FALL_SHIFT) && (LINK.addr <= `ISCR_OFS_BLACK_VS);
  wire logic [3:0] idx = rel_addr[3:0];
  wire logic wr_en = LINK.req && LINK.we && hit;
  // unmapped and reserved slots answer a fixed value, never a floating one
  wire logic [7:0] rdata_nxt = hit ? reg_r[idx] : `ISCR_RD_UNMAPPED;

  genvar gi;
  generate
    for (gi = 0; gi < `ISCR_NUM_REGS; gi++) begin : g_reg
      wire logic sel = wr_en && (idx == 4'(gi));
      // reserved bits keep reset value so a stray write cannot reach test modes
      wire logic [7:0] reg_nxt = (LINK.wdata & WR_MASK[gi]) | (reg_r[gi] & ~WR_MASK[gi]);
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          reg_r[gi] <= RST_VAL[gi];
        end else if (sel) begin
          reg_r[gi] <= reg_nxt;
        end
      end
    end
  endgenerate

  // ************************************************************
  // link answer
  // ************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_r <= 1'b0;
      rdata_r <= `ISCR_RD_UNMAPPED;
    end else begin
      ack_r <= LINK.req;
      rdata_r <= LINK.req ? rdata_nxt : rdata_r;
    end
  end
  assign LINK.ack = ack_r;
  assign LINK.rdata = rdata_r;

  // ************************************************************
  // decoding
  // ************************************************************
  wire logic [7:0] gain_rate = reg_r[1];
  wire logic [7:0] flip_exp = reg_r[2];
  wire logic [7:0] power_tri = reg_r[3];
  wire logic [7:0] fast_thr = reg_r[4];
  wire logic [7:0] black_vs = reg_r[10];

  wire logic [9:0] fall_raw = {FALL_SHIFT_UPPER, reg_r[0]};
  wire logic [9:0] fall_nxt = (fall_raw > `ISCR_HSYNC_MAX) ? `ISCR_HSYNC_MAX : fall_raw;

  wire logic [1:0] gain_code = gain_rate[`ISCR_B_GAIN_HI:`ISCR_B_GAIN_LO];
  wire logic [4:0] gain_nxt = (gain_code == 2'h1) ? `ISCR_GAIN_DB_12 :
                              (gain_code == 2'h3) ? `ISCR_GAIN_DB_18 :
                              `ISCR_GAIN_DB_6;

  wire logic [2:0] rate_sel = gain_rate[2:0];
  wire logic rate_long = gain_rate[`ISCR_B_RATE_SET];
  wire logic rate_ok = (rate_sel == `ISCR_RATE_SEL_A) || (rate_sel == `ISCR_RATE_SEL_B) ||
                       (rate_sel == `ISCR_RATE_SEL_C);
  wire logic [8:0] rate_short = (rate_sel == `ISCR_RATE_SEL_A) ? `ISCR_FIELDS_128 :
                                (rate_sel == `ISCR_RATE_SEL_B) ? `ISCR_FIELDS_64 :
                                `ISCR_FIELDS_32;
  wire logic [8:0] rate_wide = (rate_sel == `ISCR_RATE_SEL_A) ? `ISCR_FIELDS_256 :
                               (rate_sel == `ISCR_RATE_SEL_B) ? `ISCR_FIELDS_128 :
                               `ISCR_FIELDS_64;
  // an invalid code keeps the last good interval rather than guessing one
  wire logic [8:0] rate_nxt = !rate_ok ? EXP_UPDATE_FIELDS :
                              (rate_long ? rate_wide : rate_short);

  wire logic pd_nxt = power_tri[`ISCR_B_SW_PD];
  wire logic bus_float = pd_nxt && power_tri[`ISCR_B_TRI_PD];
  wire logic timing_float = bus_float || power_tri[`ISCR_B_TRI_TIMING];
  wire logic vs_nxt = !(black_vs[`ISCR_B_VS_DROP] && FRAME_DROPPED);
  wire logic bl_en_nxt = black_vs[`ISCR_B_BL_EN];
  wire logic bl_cal_nxt = black_vs[`ISCR_B_BL_CAL] && bl_en_nxt;

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HSYNC_FALL_POS <= '0;
      MAX_GAIN_DB <= `ISCR_GAIN_DB_6;
      EXP_UPDATE_FIELDS <= `ISCR_FIELDS_32;
      EXP_CODE_BAD <= 1'b0;
      UV_AWB_EN <= 1'b0;
      VFLIP <= 1'b0;
      DROP_ON_EXP_JUMP <= 1'b0;
      SMOOTH_LOW_EXP <= 1'b0;
      EXP_LOW_BITS <= '0;
      FAST_HI_THR <= 1'b0;
      FAST_LO_THR <= 1'b0;
      AVG_LEVEL <= '0;
      AVG_LEVEL_VALID <= 1'b0;
    end else begin
      HSYNC_FALL_POS <= fall_nxt;
      MAX_GAIN_DB <= gain_nxt;
      EXP_UPDATE_FIELDS <= rate_nxt;
      EXP_CODE_BAD <= !rate_ok;
      UV_AWB_EN <= gain_rate[`ISCR_B_UV_AWB];
      VFLIP <= flip_exp[`ISCR_B_VFLIP];
      DROP_ON_EXP_JUMP <= flip_exp[`ISCR_B_DROP_CHG];
      SMOOTH_LOW_EXP <= flip_exp[`ISCR_B_SMOOTH];
      EXP_LOW_BITS <= power_tri[1:0];
      FAST_HI_THR <= fast_thr[`ISCR_B_FAST_HI];
      FAST_LO_THR <= fast_thr[`ISCR_B_FAST_LO];
      AVG_LEVEL <= AVG_ENABLE ? reg_r[9] : '0;
      AVG_LEVEL_VALID <= AVG_ENABLE;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      VSYNC_ENABLE <= 1'b1;
      BLACK_LINE_EN <= 1'b0;
      BLACK_LINE_CAL <= 1'b0;
      POWER_DOWN <= 1'b0;
      DATA_OE_N <= 1'b0;
      TIMING_OE_N <= 1'b0;
    end else begin
      VSYNC_ENABLE <= vs_nxt;
      BLACK_LINE_EN <= bl_en_nxt;
      BLACK_LINE_CAL <= bl_cal_nxt;
      POWER_DOWN <= pd_nxt;
      DATA_OE_N <= bus_float;
      TIMING_OE_N <= timing_float;
    end
  end

  // ************************************************************
  // colour offsets, one converter per channel
  // ************************************************************
  logic signed [OFS_W:0] ofs_w [0:2];
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ofs
      iscr_offset #(.W(OFS_W)) u_ofs (
        .clk(CLK),
        .rstn(RSTN),
        .code(reg_r[5+gi][OFS_W-1:0]),
        .offset(ofs_w[gi])
      );
    end
  endgenerate
  assign LUMA_OFFSET = ofs_w[0];
  assign BLUE_OFFSET = ofs_w[1];
  assign RED_OFFSET = ofs_w[2];

endmodule : iscr_device
`default_nettype wire

// ==== rtl/iscr_host.sv ====
// host controller end: issues register accesses and guards illegal ones
// assumes the device answers every request with ack one cycle later
`timescale 1ns/10ps
`default_nettype none
`include "iscr_cfg.svh"
module iscr_host (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register link
  iscr_link_if.host LINK,
  // rising edge setting held elsewhere, and upper falling bits
  input wire logic [9:0] HSYNC_RISE_SHIFT,
  input wire logic [1:0] FALL_SHIFT_UPPER,
  // user command port
  input wire logic USER_REQ,
  input wire logic USER_WE,
  input wire logic [7:0] USER_ADDR,
  input wire logic [7:0] USER_WDATA,
  output logic USER_BUSY,
  output logic USER_DONE,
  output logic USER_REFUSED,
  output logic [7:0] USER_RDATA
);

  // ************************************************************
  // guards
  // ************************************************************
  wire logic listed = (USER_ADDR >= `ISCR_OFS_FALL_SHIFT) && (USER_ADDR <= `ISCR_OFS_BLACK_VS) &&
                      (USER_ADDR != `ISCR_OFS_RESERVED_SLOT_A_A);
  wire logic bad_reserved_slot_a = USER_WE && !listed;
  wire logic [2:0] sel = USER_WDATA[2:0];
  wire logic sel_ok = (sel == `ISCR_RATE_SEL_A) || (sel == `ISCR_RATE_SEL_B) ||
                      (sel == `ISCR_RATE_SEL_C);
  wire logic bad_rate = USER_WE && (USER_ADDR == `ISCR_OFS_GAIN_RATE) && !sel_ok;
  wire logic [9:0] fall_new = {FALL_SHIFT_UPPER, USER_WDATA};
  // falling edge must stay strictly after the rising one
  wire logic bad_order = USER_WE && (USER_ADDR == `ISCR_OFS_FALL_SHIFT) &&
                         (fall_new <= HSYNC_RISE_SHIFT);
  wire logic refuse = bad_reserved_slot_a || bad_rate || bad_order;

  iscr_pkg::iscr_hstate_type state_r, state_nxt;
  wire logic start = (state_r == iscr_pkg::ISCR_HS_IDLE) && USER_REQ && !refuse;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      iscr_pkg::ISCR_HS_IDLE: begin
        if (start) begin
          state_nxt = iscr_pkg::ISCR_HS_WAIT;
        end
      end
      iscr_pkg::ISCR_HS_WAIT: begin
        if (LINK.ack) begin
          state_nxt = iscr_pkg::ISCR_HS_IDLE;
        end
      end
      default: begin
        state_nxt = iscr_pkg::ISCR_HS_IDLE;
      end
    endcase
  end

  // ************************************************************
  // link drive and user answer
  // ************************************************************
  logic req_r;
  logic we_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  wire logic finish = (state_r == iscr_pkg::ISCR_HS_WAIT) && LINK.ack;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= iscr_pkg::ISCR_HS_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      req_r <= start;
      we_r <= start ? USER_WE : we_r;
      addr_r <= start ? USER_ADDR : addr_r;
      wdata_r <= start ? USER_WDATA : wdata_r;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      USER_BUSY <= 1'b0;
      USER_DONE <= 1'b0;
      USER_REFUSED <= 1'b0;
      USER_RDATA <= '0;
    end else begin
      USER_BUSY <= (state_nxt != iscr_pkg::ISCR_HS_IDLE);
      USER_DONE <= finish;
      USER_REFUSED <= (state_r == iscr_pkg::ISCR_HS_IDLE) && USER_REQ && refuse;
      USER_RDATA <= (finish && !we_r) ? LINK.rdata : USER_RDATA;
    end
  end

  assign LINK.req = req_r;
  assign LINK.we = we_r;
  assign LINK.addr = addr_r;
  assign LINK.wdata = wdata_r;

endmodule : iscr_host
`default_nettype wire

// ==== tb/iscr_chk.sv ====
// link checker: watches the register link between host and device
// assumes one clock domain and instantiation beside the link interface
`timescale 1ns/10ps
`default_nettype none
module iscr_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // link signals
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  // ************************************************************
  // shadows of two fully writable registers
  // ************************************************************
  logic [7:0] fall_r;
  logic [7:0] luma_r;
  wire logic wr_go = req && we;
  wire logic unmapped = addr < 8'h73 || addr > 8'h7d || addr == 8'h7b;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fall_r <= 8'h50;
      luma_r <= 8'h80;
    end else begin
      if (wr_go && addr == 8'h73) fall_r <= wdata;
      if (wr_go && addr == 8'h78) luma_r <= wdata;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_read(a);
    req && !we && addr == a;
  endsequence
  sequence s_answer(v);
    ack && rdata == v;
  endsequence

  a_ack_follows: assert property (req |=> ack)
    else $error("ack missing after request");
  a_ack_caused: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_one_outstanding: assert property (req |=> !req)
    else $error("request while one is outstanding");
  // read data must not wander between requests
  a_rdata_stable: assert property (!req |=> $stable(rdata))
    else $error("read data changed without request");
  a_unmapped_zero: assert property (req && !we && unmapped |=> s_answer(8'h00))
    else $error("reserved read not zero");
  a_fall_readback: assert property (s_read(8'h73) |=> s_answer(fall_r))
    else $error("falling shift readback wrong");
  a_luma_readback: assert property (s_read(8'h78) |=> s_answer(luma_r))
    else $error("luma offset readback wrong");
  a_reserved_slot_a_bit_zero: assert property (s_read(8'h74) |=> ack && !rdata[4])
    else $error("reserved bit of rate register set");
  a_rate_onehot: assert property (wr_go && addr == 8'h74 |-> $onehot(wdata[2:0]))
    else $error("illegal rate code forwarded");
  a_write_listed: assert property (wr_go |-> !unmapped)
    else $error("write to unlisted register forwarded");
endmodule : iscr_chk
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench: host and device joined by the register link
// assumes rtl files, package and link interface compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] rise = 10'h010;
  logic [1:0] upper = 2'h0;
  logic avg_en = 1'b0;
  logic dropped = 1'b0;
  logic u_req = 1'b0;
  logic u_we = 1'b0;
  logic [7:0] u_addr = 8'h00;
  logic [7:0] u_wdata = 8'h00;
  wire logic busy, done, refused, vs_en, vflip, awb, bad, drop_j, smooth;
  wire logic f_hi, f_lo, avg_ok, bl_en, bl_cal, pd, doe_n, toe_n;
  wire logic [7:0] u_rdata;
  wire logic [7:0] average_level_store;
  wire logic [9:0] fall_pos;
  wire logic [4:0] gain;
  wire logic [8:0] fields;
  wire logic [1:0] low;
  wire logic signed [8:0] ofs_y, ofs_u, ofs_v;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  logic was_ref;
  logic was_busy;
  logic [7:0] rd;
  logic [7:0] rst_tab [0:12] = '{8'h00, 8'h50, 8'h20, 8'h02, 8'h05, 8'hf3, 8'h80,
                                 8'h80, 8'h80, 8'h00, 8'h00, 8'h77, 8'h00};
  logic [4:0] gtab [0:3] = '{5'h06, 5'h0c, 5'h06, 5'h12};
  logic [7:0] pw [0:3] = '{8'h20, 8'ha0, 8'h07, 8'h81};
  logic [4:0] pe [0:3] = '{5'b10000, 5'b11100, 5'b00111, 5'b00001};

  always #12.5 clk = ~clk;

  iscr_link_if link ();
  iscr_device iscr_device_i (.CLK(clk), .RSTN(rstn), .LINK(link), .FALL_SHIFT_UPPER(upper),
    .AVG_ENABLE(avg_en), .FRAME_DROPPED(dropped), .HSYNC_FALL_POS(fall_pos),
    .VSYNC_ENABLE(vs_en), .VFLIP(vflip), .UV_AWB_EN(awb), .MAX_GAIN_DB(gain),
    .EXP_UPDATE_FIELDS(fields), .EXP_CODE_BAD(bad), .DROP_ON_EXP_JUMP(drop_j),
    .SMOOTH_LOW_EXP(smooth), .EXP_LOW_BITS(low), .FAST_HI_THR(f_hi), .FAST_LO_THR(f_lo),
    .AVG_LEVEL(average_level_store), .AVG_LEVEL_VALID(avg_ok), .LUMA_OFFSET(ofs_y), .BLUE_OFFSET(ofs_u),
    .RED_OFFSET(ofs_v), .BLACK_LINE_EN(bl_en), .BLACK_LINE_CAL(bl_cal), .POWER_DOWN(pd),
    .DATA_OE_N(doe_n), .TIMING_OE_N(toe_n));
  iscr_host iscr_host_i (.CLK(clk), .RSTN(rstn), .LINK(link), .HSYNC_RISE_SHIFT(rise),
    .FALL_SHIFT_UPPER(upper), .USER_REQ(u_req), .USER_WE(u_we), .USER_ADDR(u_addr),
    .USER_WDATA(u_wdata), .USER_BUSY(busy), .USER_DONE(done), .USER_REFUSED(refused),
    .USER_RDATA(u_rdata));
  iscr_chk iscr_chk_i (.CLK(clk), .RSTN(rstn), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // one user access; the extra edge lets decoded outputs settle
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    u_req <= 1'b1;
    u_we <= w;
    u_addr <= a;
    u_wdata <= d;
    @(posedge clk);
    u_req <= 1'b0;
    n = 0;
    #1;
    was_busy = busy;
    while (done !== 1'b1 && refused !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 8, 1'b1);
    was_ref = refused;
    rd = u_rdata;
    @(posedge clk);
    #1;
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r);
    op(1'b1, a, d);
    chk({was_ref, was_busy}, {r, !r});
  endtask : wr

  task automatic rdr(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, a, 8'h00);
    chk({was_busy, rd}, {1'b1, e});
  endtask : rdr

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    // decoded outputs show the register defaults one edge after release
    @(posedge clk);
    #1;
    chk(fall_pos, 10'h050);
    chk({gain, bad, fields}, {5'h0c, 1'b1, 9'h020});
    chk({pd, doe_n, toe_n}, 3'b001);
    chk({bl_cal, bl_en, vs_en}, 3'b011);
    chk({ofs_y, ofs_u, ofs_v}, 27'h0);
    for (int i = 0; i < 13; i++) begin
      rdr(8'h72 + 8'(i), rst_tab[i]);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_hsync;
    @(posedge clk);
    upper <= 2'h3;
    wr(8'h73, 8'h5a, 1'b0);
    chk(fall_pos, 10'h35a);
    rdr(8'h73, 8'h5a);
    wr(8'h73, 8'hff, 1'b0);
    chk(fall_pos, 10'h35a);
    @(posedge clk);
    upper <= 2'h1;
    repeat (2) @(posedge clk);
    #1;
    chk(fall_pos, 10'h1ff);
    wr(8'h73, 8'h20, 1'b0);
    @(posedge clk);
    rise <= 10'h130;
    wr(8'h73, 8'h30, 1'b1);
    chk(fall_pos, 10'h120);
    $display("test hsync done");
  endtask : t_hsync

  task automatic t_gain_rate;
    logic [7:0] d;
    for (int j = 0; j < 6; j++) begin
      d = {j[0], j[1:0], 1'b1, j >= 3, 3'b001 << (j % 3)};
      wr(8'h74, d, 1'b0);
      chk({awb, gain}, {j[0], gtab[j % 4]});
      chk({bad, fields}, (9'h080 >> (j % 3)) << (j / 3));
      rdr(8'h74, d & 8'hef);
    end
    wr(8'h74, 8'h03, 1'b1);
    $display("test gain and rate done");
  endtask : t_gain_rate

  task automatic t_flip_power;
    wr(8'h75, 8'hff, 1'b0);
    chk({vflip, drop_j, smooth}, 3'b111);
    rdr(8'h75, 8'h8e);
    for (int i = 0; i < 4; i++) begin
      wr(8'h76, pw[i], 1'b0);
      chk({pd, doe_n, toe_n, low}, pe[i]);
    end
    $display("test flip and power done");
  endtask : t_flip_power

  task automatic t_levels;
    wr(8'h77, 8'h80, 1'b0);
    chk({f_hi, f_lo}, 2'b10);
    wr(8'h77, 8'h40, 1'b0);
    chk({f_hi, f_lo}, 2'b01);
    wr(8'h78, 8'h00, 1'b0);
    wr(8'h79, 8'hff, 1'b0);
    wr(8'h7a, 8'h80, 1'b0);
    chk({ofs_y, ofs_u, ofs_v}, {9'h180, 9'h07f, 9'h000});
    rdr(8'h78, 8'h00);
    wr(8'h7c, 8'ha5, 1'b0);
    chk({avg_ok, average_level_store}, 9'h000);
    @(posedge clk);
    avg_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({avg_ok, average_level_store}, 9'h1a5);
    $display("test levels done");
  endtask : t_levels

  task automatic t_black_vsync;
    wr(8'h7d, 8'h80, 1'b0);
    chk({bl_en, bl_cal}, 2'b00);
    wr(8'h7d, 8'hc0, 1'b0);
    chk({bl_en, bl_cal, vs_en}, 3'b111);
    @(posedge clk);
    dropped <= 1'b1;
    wr(8'h7d, 8'h04, 1'b0);
    chk(vs_en, 1'b0);
    wr(8'h7d, 8'h00, 1'b0);
    chk(vs_en, 1'b1);
    wr(8'h7b, 8'hff, 1'b1);
    wr(8'h7e, 8'h12, 1'b1);
    rdr(8'h7b, 8'h00);
    rdr(8'h7f, 8'h00);
    $display("test black line and reserved done");
  endtask : t_black_vsync

  // ************************************************************
  // run control
  // ************************************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_hsync();
    t_gain_rate();
    t_flip_power();
    t_levels();
    t_black_vsync();
    test_done();
  end
endmodule : testbench
`default_nettype wire
